/* File: common/sal_regs.svh */
// Constants for the slave addressing and alias bridge block.
// Assumes inclusion by bare name from the design files.
`ifndef SAL_REGS_SVH
`define SAL_REGS_SVH
// ****************************************
// Address decode
// ****************************************
`define SAL_TX_BASE 7'h58
`define SAL_TX_MAX_IDX 3'h5
`define SAL_RX_BASE 7'h60
`define SAL_ALIAS_N 8
// ****************************************
// Timing
// ****************************************
`define SAL_STRAP_WAIT 2'h3
`define SAL_BIT_NS 2500
`define SAL_CLK_NS 100
`define SAL_BIT_CYC ((`SAL_BIT_NS) / (`SAL_CLK_NS))
`endif

/* File: common/sal_pkg.sv */
// Types shared by the slave addressing and alias bridge block.
// Assumes nothing beyond a SystemVerilog compiler.
package sal_pkg;
    // One alias entry: enable, incoming match, remote target
    typedef struct packed {
        logic en;
        logic [6:0] match;
        logic [6:0] target;
    } sal_alias_t;

    typedef enum logic [1:0] {
        LK_ADDR,
        LK_WRITE,
        LK_READ,
        LK_STOP
    } sal_link_kind_t;

    typedef struct packed {
        sal_link_kind_t kind;
        logic [7:0] data;
    } sal_link_req_t;

    typedef struct packed {
        logic ack;
        logic [7:0] data;
    } sal_link_rsp_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WDATA,
        ST_WAIT,
        ST_ACK,
        ST_RDATA,
        ST_RACK,
        ST_SKIP,
        ST_STOP
    } sal_state_t;
endpackage : sal_pkg

/* File: hdl/sal_sync2.sv */
// Two flip-flop synchroniser for levels entering a clock domain.
// Assumes the input is quasi-static relative to the destination clock.
`timescale 1ns/1ns
`default_nettype none
module sal_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sal_sync2
`default_nettype wire

/* File: hdl/sal_alias_bridge.sv */
// Receiver-side I2C slave with strap addressing, alias remap and link bridge.
// Assumes SCL/SDA are open-drain pins resolved outside; the link partner
// answers each request on link_clock with a one-cycle link_rsp_valid.
`timescale 1ns/1ns
`default_nettype none
`include "sal_regs.svh"
module sal_alias_bridge import sal_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic link_clock,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe_n,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [2:0] tx_address_strap,
    input wire logic [1:0] rx_strap_low,
    input wire logic [1:0] rx_strap_high,
    input wire logic camera_mode,
    input wire logic pass_through_en,
    input wire sal_alias_t [`SAL_ALIAS_N-1:0] alias_table,
    input wire logic [7:0] cfg_rd_data,
    output logic strap_valid,
    output logic [6:0] tx_slave_addr,
    output logic [6:0] rx_slave_addr,
    output logic [7:0] tx_write_byte,
    output logic [7:0] rx_write_byte,
    output logic cfg_wr_valid,
    output logic [7:0] cfg_wr_data,
    output logic cfg_rd_strobe,
    output logic link_req_valid,
    output sal_link_req_t link_req,
    input wire logic link_rsp_valid,
    input wire sal_link_rsp_t link_rsp
);
    // ****************************************
    // Pin sampling and bus conditions
    // ****************************************
    logic [1:0] pin_s;
    logic scl_s, sda_s, scl_d_r, sda_d_r;
    logic scl_rise, scl_fall, start_c, stop_c;

    sal_sync2 #(.W(2)) u_pin_sync (
        .clk(clock),
        .rst_n(rst_n),
        .d({scl_in, sda_in}),
        .q(pin_s)
    );
    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];

    // Previous samples for edge and condition detection
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r <= 1'b0;
            sda_d_r <= 1'b0;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // 25 clocks per fast-mode bit leave ample margin over sync delay
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ****************************************
    // Strap capture and address decode
    // ****************************************
    logic [6:0] strap_s, strap_q_r;
    logic [1:0] strap_cnt_r;
    logic [2:0] tx_idx;

    sal_sync2 #(.W(7)) u_strap_sync (
        .clk(clock),
        .rst_n(rst_n),
        .d({tx_address_strap, rx_strap_high, rx_strap_low}),
        .q(strap_s)
    );

    // Indices past the sixth level clamp to the highest address
    assign tx_idx = (strap_s[6:4] > `SAL_TX_MAX_IDX) ? `SAL_TX_MAX_IDX : strap_s[6:4];

    // Sampled once; later strap movement is ignored by design
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_r <= 2'h0;
            strap_valid <= 1'b0;
            tx_slave_addr <= 7'h00;
            rx_slave_addr <= 7'h00;
        end else if (!strap_valid) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == `SAL_STRAP_WAIT) begin
                strap_valid <= 1'b1;
                tx_slave_addr <= `SAL_TX_BASE + {4'h0, tx_idx};
                rx_slave_addr <= `SAL_RX_BASE + {3'h0, strap_s[3:0]};
            end
        end
    end

    // Helper copy of the straps for checking
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_q_r <= 7'h00;
        end else begin
            strap_q_r <= strap_s;
        end
    end

    // Write-direction address bytes
    assign tx_write_byte = {tx_slave_addr, 1'b0};
    assign rx_write_byte = {rx_slave_addr, 1'b0};

    // ****************************************
    // Alias table lookup
    // ****************************************
    logic [7:0] shift_r;
    logic [`SAL_ALIAS_N-1:0] hit;
    logic [2:0] sel;
    logic [6:0] alias_tgt;
    logic alias_ok;

    // One comparator per entry
    for (genvar g = 0; g < `SAL_ALIAS_N; g++) begin : g_alias
        assign hit[g] = alias_table[g].en && (alias_table[g].match == shift_r[7:1]);
    end

    // Lowest matching entry wins
    always_comb begin
        sel = 3'h0;
        for (int i = `SAL_ALIAS_N - 1; i >= 0; i--) begin
            if (hit[i]) begin
                sel = 3'(i);
            end
        end
    end
    assign alias_tgt = alias_table[sel].target;
    assign alias_ok = camera_mode & (|hit);

    // ****************************************
    // Slave state machine
    // ****************************************
    sal_state_t state_r;
    sal_link_req_t req_r, req_nxt;
    sal_link_rsp_t rsp_hold_r;
    logic [3:0] cnt_r;
    logic [7:0] tx_r, rdata_r;
    logic own_r, fwd_r, rw_r, nack_r, scl_hold_r, sda_low_r, req_tgl_r;
    logic ack_s, ack_d_r, ack_evt, ack_tgl_r, own_hit;

    assign own_hit = strap_valid && (shift_r[7:1] == rx_slave_addr);

    // Request built from the byte just shifted in
    always_comb begin
        req_nxt.kind = (state_r == ST_ADDR) ? LK_ADDR : (state_r == ST_WDATA) ? LK_WRITE : LK_READ;
        req_nxt.data = shift_r;
        if (state_r == ST_ADDR && alias_ok) begin
            req_nxt.data = {alias_tgt, shift_r[0]};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_d_r <= 1'b0;
        end else begin
            ack_d_r <= ack_s;
        end
    end
    assign ack_evt = ack_s ^ ack_d_r;

    // Byte framing, forwarding decisions and stretching
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            cnt_r <= 4'h0;
            tx_r <= 8'h00;
            rdata_r <= 8'h00;
            own_r <= 1'b0;
            fwd_r <= 1'b0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            scl_hold_r <= 1'b0;
            sda_low_r <= 1'b0;
            req_r <= '0;
            req_tgl_r <= 1'b0;
            cfg_wr_valid <= 1'b0;
            cfg_wr_data <= 8'h00;
            cfg_rd_strobe <= 1'b0;
        end else begin
            cfg_wr_valid <= 1'b0;
            cfg_rd_strobe <= 1'b0;
            if (start_c && state_r != ST_STOP) begin
                // Repeated start re-addresses; remote sees a fresh address
                state_r <= ST_ADDR;
                cnt_r <= 4'h0;
                sda_low_r <= 1'b0;
                own_r <= 1'b0;
                fwd_r <= 1'b0;
                nack_r <= 1'b0;
            end else if (stop_c) begin
                sda_low_r <= 1'b0;
                own_r <= 1'b0;
                fwd_r <= 1'b0;
                state_r <= ST_IDLE;
                if (fwd_r) begin
                    req_r <= '{kind: LK_STOP, data: 8'h00};
                    req_tgl_r <= ~req_tgl_r;
                    state_r <= ST_STOP;
                end
            end else begin
                case (state_r)
                    ST_ADDR, ST_WDATA: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == 4'h8) begin
                            cnt_r <= 4'h0;
                            if (state_r == ST_ADDR) begin
                                rw_r <= shift_r[0];
                            end
                            if ((state_r == ST_ADDR && own_hit) || (state_r == ST_WDATA && own_r)) begin
                                own_r <= 1'b1;
                                sda_low_r <= 1'b1;
                                state_r <= ST_ACK;
                                cfg_wr_valid <= (state_r == ST_WDATA);
                                cfg_wr_data <= shift_r;
                            end else if (state_r == ST_WDATA || alias_ok || pass_through_en) begin
                                // Forward and stretch the ninth clock
                                fwd_r <= 1'b1;
                                req_r <= req_nxt;
                                req_tgl_r <= ~req_tgl_r;
                                scl_hold_r <= 1'b1;
                                state_r <= ST_WAIT;
                            end else begin
                                state_r <= ST_SKIP;
                            end
                        end
                    end
                    ST_WAIT: begin
                        // SCL stays low until the remote answer arrives
                        if (ack_evt) begin
                            scl_hold_r <= 1'b0;
                            rdata_r <= rsp_hold_r.data;
                            if (req_r.kind == LK_READ) begin
                                tx_r <= rsp_hold_r.data;
                                sda_low_r <= ~rsp_hold_r.data[7];
                                cnt_r <= 4'h0;
                                state_r <= ST_RDATA;
                            end else begin
                                sda_low_r <= rsp_hold_r.ack;
                                nack_r <= ~rsp_hold_r.ack;
                                state_r <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            cnt_r <= 4'h0;
                            if (nack_r) begin
                                sda_low_r <= 1'b0;
                                state_r <= ST_SKIP;
                            end else if (rw_r) begin
                                tx_r <= own_r ? cfg_rd_data : rdata_r;
                                sda_low_r <= own_r ? ~cfg_rd_data[7] : ~rdata_r[7];
                                cfg_rd_strobe <= own_r;
                                state_r <= ST_RDATA;
                            end else begin
                                sda_low_r <= 1'b0;
                                state_r <= ST_WDATA;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_rise) begin
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_r == 4'h8) begin
                                sda_low_r <= 1'b0;
                                state_r <= ST_RACK;
                            end else begin
                                tx_r <= {tx_r[6:0], 1'b0};
                                sda_low_r <= ~tx_r[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            nack_r <= sda_s;
                        end else if (scl_fall) begin
                            cnt_r <= 4'h0;
                            if (nack_r) begin
                                state_r <= ST_SKIP;
                            end else if (own_r) begin
                                tx_r <= cfg_rd_data;
                                sda_low_r <= ~cfg_rd_data[7];
                                cfg_rd_strobe <= 1'b1;
                                state_r <= ST_RDATA;
                            end else begin
                                req_r <= req_nxt;
                                req_tgl_r <= ~req_tgl_r;
                                scl_hold_r <= 1'b1;
                                state_r <= ST_WAIT;
                            end
                        end
                    end
                    ST_STOP: begin
                        // A start arriving here is missed; stops are short
                        if (ack_evt) begin
                            state_r <= ST_IDLE;
                        end
                    end
                    ST_IDLE, ST_SKIP: begin
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Open-drain drive: enable low pulls the wire low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = ~scl_hold_r;
    assign sda_oe_n = ~sda_low_r;

    // ****************************************
    // Link clock domain: toggle handshake
    // ****************************************
    logic req_s, req_seen_r;

    sal_sync2 #(.W(1)) u_req_sync (
        .clk(link_clock),
        .rst_n(rst_n),
        .d(req_tgl_r),
        .q(req_s)
    );
    sal_sync2 #(.W(1)) u_ack_sync (
        .clk(clock),
        .rst_n(rst_n),
        .d(ack_tgl_r),
        .q(ack_s)
    );

    // req_r is stable while its toggle is in flight
    always_ff @(posedge link_clock or negedge rst_n) begin
        if (!rst_n) begin
            req_seen_r <= 1'b0;
            link_req_valid <= 1'b0;
            link_req <= '0;
            rsp_hold_r <= '0;
            ack_tgl_r <= 1'b0;
        end else if (!link_req_valid && req_s != req_seen_r) begin
            req_seen_r <= req_s;
            link_req_valid <= 1'b1;
            link_req <= req_r;
        end else if (link_req_valid && link_rsp_valid) begin
            link_req_valid <= 1'b0;
            rsp_hold_r <= link_rsp;
            ack_tgl_r <= ~ack_tgl_r;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    logic addr_done;
    assign addr_done = state_r == ST_ADDR && scl_fall && cnt_r == 4'h8 && !own_hit;

    property p_tx_range;
        @(posedge clock) disable iff (!rst_n)
        strap_valid |-> tx_slave_addr >= `SAL_TX_BASE && tx_slave_addr <= 7'h5D;
    endproperty
    a_tx_range: assert property (p_tx_range) else $error("tx address out of range");

    property p_wbyte;
        @(posedge clock) disable iff (!rst_n)
        strap_valid |-> rx_write_byte == {rx_slave_addr, 1'b0} && !tx_write_byte[0];
    endproperty
    a_wbyte: assert property (p_wbyte) else $error("write byte mismatch");

    property p_rx_addr;
        @(posedge clock) disable iff (!rst_n)
        $rose(strap_valid) |-> rx_slave_addr == `SAL_RX_BASE + {3'h0, strap_q_r[3:0]};
    endproperty
    a_rx_addr: assert property (p_rx_addr) else $error("rx address decode wrong");

    property p_stretch;
        @(posedge clock) disable iff (!rst_n)
        state_r == ST_WAIT |-> !scl_oe_n;
    endproperty
    a_stretch: assert property (p_stretch) else $error("scl not held while waiting");

    property p_release;
        @(posedge clock) disable iff (!rst_n)
        $fell(scl_hold_r) |-> $past(ack_evt);
    endproperty
    a_release: assert property (p_release) else $error("scl released early");

    property p_alias;
        @(posedge clock) disable iff (!rst_n)
        addr_done && alias_ok |=> req_r.data[7:1] == $past(alias_tgt) && state_r == ST_WAIT;
    endproperty
    a_alias: assert property (p_alias) else $error("alias target not used");

    property p_ignore;
        @(posedge clock) disable iff (!rst_n)
        addr_done && !(camera_mode && |hit) && !pass_through_en |=> state_r == ST_SKIP;
    endproperty
    a_ignore: assert property (p_ignore) else $error("unmatched address taken");

    property p_pass;
        @(posedge clock) disable iff (!rst_n)
        addr_done && !alias_ok && pass_through_en |=> req_r.data == $past(shift_r);
    endproperty
    a_pass: assert property (p_pass) else $error("pass-through altered address");

    property p_own;
        @(posedge clock) disable iff (!rst_n)
        cfg_wr_valid |-> own_r && state_r == ST_ACK && sda_low_r;
    endproperty
    a_own: assert property (p_own) else $error("config write without own ack");

    property p_link;
        @(posedge link_clock) disable iff (!rst_n)
        link_req_valid && link_rsp_valid |=> !link_req_valid ##1 !link_req_valid;
    endproperty
    a_link: assert property (p_link) else $error("link request not retired");

    property p_sda;
        @(posedge clock) disable iff (!rst_n)
        $changed(sda_low_r) && !start_c && !stop_c |-> !scl_s;
    endproperty
    a_sda: assert property (p_sda) else $error("sda moved while scl high");

    c_own_write: cover property (@(posedge clock) cfg_wr_valid);
    c_alias_fwd: cover property (@(posedge clock) addr_done && alias_ok);
    c_pass_fwd: cover property (@(posedge clock) addr_done && !alias_ok && pass_through_en);
    c_read: cover property (@(posedge clock) state_r == ST_WAIT ##1 state_r == ST_RDATA);
endmodule : sal_alias_bridge
`default_nettype wire

/* File: tb/sal_link_partner.sv */
// Behavioural far end of the link: replays requests on the remote bus.
// Assumes requests are held until answered, one at a time.
`timescale 1ns/1ns
`default_nettype none
module sal_link_partner import sal_pkg::*; (
    input wire logic link_clock,
    input wire logic rst_n,
    input wire logic link_req_valid,
    input wire sal_link_req_t link_req,
    input wire logic remote_ack,
    output logic link_rsp_valid,
    output sal_link_rsp_t link_rsp,
    output logic [7:0] last_addr
);
    // ****************************************
    // Answer engine
    // ****************************************
    logic busy_r;
    logic [2:0] wait_r;
    // Random delay per request covers prompt and slow remotes
    always_ff @(posedge link_clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            wait_r <= 3'h0;
            link_rsp_valid <= 1'b0;
            link_rsp <= '0;
            last_addr <= 8'h00;
        end else begin
            // Pulse in the cycle the answer is placed; stale data never looks valid
            link_rsp_valid <= busy_r && wait_r == 3'h1;
            if (!(busy_r && wait_r == 3'h1)) link_rsp.data <= ~link_rsp.data;
            if (!busy_r && link_req_valid) begin
                busy_r <= 1'b1;
                wait_r <= 3'($urandom_range(1, 6));
                if (link_req.kind == LK_ADDR) last_addr <= link_req.data;
            end else if (busy_r && wait_r > 3'h1) begin
                wait_r <= wait_r - 3'h1;
            end else if (busy_r && wait_r == 3'h1) begin
                wait_r <= 3'h0;
                link_rsp <= {remote_ack, link_req.data ^ 8'hA5};
            end else if (busy_r && !link_req_valid) begin
                busy_r <= 1'b0; // Wait for the request to drop first
            end
        end
    end
endmodule : sal_link_partner
`default_nettype wire

/* File: tb/sal_alias_bridge_tb.sv */
// Self-checking bench for the alias bridge with a behavioural link partner.
// Assumes open-drain bus pins resolved here with pull-ups.
`timescale 1ns/1ns
`default_nettype none
`include "sal_regs.svh"
module sal_alias_bridge_tb import sal_pkg::*;;
    logic clock = 0, rst_n = 0, link_clock = 0, scl_m = 1, sda_m = 1, ack, stretched = 0;
    logic camera_mode = 1, pass_through_en = 0, remote_ack = 1;
    logic [2:0] tx_strap = 3'h0;
    logic [1:0] s_lo = 2'h0, s_hi = 2'h0;
    logic [6:0] own;
    logic [7:0] rd_data = 8'h00, wr_seen = 8'h00, d, last_addr;
    sal_alias_t [`SAL_ALIAS_N-1:0] alias_table = '0;
    wire scl_oe_n, sda_oe_n, strap_valid, cfg_wr_valid, link_req_valid, link_rsp_valid, rd_stb;
    wire [6:0] tx_a, rx_a;
    wire [7:0] tx_w, rx_w, cfg_wr_data;
    wire sal_link_req_t link_req;
    wire sal_link_rsp_t link_rsp;
    int errors = 0, total_checks = 0, cyc = 0, rd_n = 0;
    wire scl = scl_m & scl_oe_n; // Pull-up wins unless someone pulls low
    wire sda = sda_m & sda_oe_n;
    always #50 clock = ~clock;
    always #32 link_clock = ~link_clock;
    sal_alias_bridge DUT (.clock(clock), .rst_n(rst_n), .link_clock(link_clock),
        .scl_in(scl), .sda_in(sda), .scl_out(), .scl_oe_n(scl_oe_n), .sda_out(),
        .sda_oe_n(sda_oe_n), .tx_address_strap(tx_strap), .rx_strap_low(s_lo),
        .rx_strap_high(s_hi), .camera_mode(camera_mode), .pass_through_en(pass_through_en),
        .alias_table(alias_table), .cfg_rd_data(rd_data), .strap_valid(strap_valid),
        .tx_slave_addr(tx_a), .rx_slave_addr(rx_a), .tx_write_byte(tx_w),
        .rx_write_byte(rx_w), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_data(cfg_wr_data),
        .cfg_rd_strobe(rd_stb), .link_req_valid(link_req_valid), .link_req(link_req),
        .link_rsp_valid(link_rsp_valid), .link_rsp(link_rsp));
    sal_link_partner pm (.link_clock(link_clock), .rst_n(rst_n),
        .link_req_valid(link_req_valid), .link_req(link_req), .remote_ack(remote_ack),
        .link_rsp_valid(link_rsp_valid), .link_rsp(link_rsp), .last_addr(last_addr));
    // ****************************************
    // Observers, timeout and helpers
    // ****************************************
    // Pulses are caught here so the bus tasks need not poll them
    always @(posedge clock) begin
        cyc++;
        if (cfg_wr_valid === 1'b1) wr_seen <= cfg_wr_data;
        if (scl_oe_n === 1'b0) stretched <= 1'b1;
        if (rd_stb === 1'b1) rd_n++;
        if (cyc == 60000) begin
            errors++;
            final_report();
        end
    end
    function automatic logic [6:0] exp_tx(input logic [2:0] s);
        return (s > 3'h5) ? 7'h5D : 7'h58 + {4'h0, s};
    endfunction : exp_tx
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
    endtask : tk
    // One bit of 25 cycles, 400 kbps; stretch waited out with a bound
    task automatic bit_io(input logic v, output logic r);
        sda_m <= v;
        tk(6);
        scl_m <= 1'b1;
        tk(1);
        for (int w = 0; w < 400 && scl !== 1'b1; w++) tk(1);
        tk(10);
        r = sda;
        tk(2);
        scl_m <= 1'b0;
        tk(6);
    endtask : bit_io
    task automatic send(input logic [7:0] b, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        a = ~r;
    endtask : send
    // Master reads a byte, then acks (last low) or nacks (last high)
    task automatic recv(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(last, r);
    endtask : recv
    task automatic i2c_start;
        sda_m <= 1'b1;
        scl_m <= 1'b1;
        tk(8);
        sda_m <= 1'b0;
        tk(8);
        scl_m <= 1'b0;
        tk(6);
        stretched <= 1'b0;
    endtask : i2c_start
    task automatic i2c_stop;
        sda_m <= 1'b0;
        tk(6);
        scl_m <= 1'b1;
        tk(8);
        sda_m <= 1'b1;
        tk(20);
    endtask : i2c_stop
    // Address-only transaction; the address byte is always a write
    task automatic xfer(input logic [6:0] a, output logic k);
        i2c_start();
        send({a, 1'b0}, k);
        i2c_stop();
    endtask : xfer
    task automatic final_report;
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h91BF667E));
        // Strap decode across resets, corners first
        for (int k = 0; k < 5; k++) begin
            tx_strap <= (k < 3) ? 3'(k * 5 - k / 2 * 3) : 3'($urandom_range(0, 5));
            s_lo <= (k == 1) ? 2'h3 : 2'($urandom);
            s_hi <= (k == 1) ? 2'h3 : 2'($urandom);
            rst_n <= 1'b0;
            tk(10);
            rst_n <= 1'b1;
            for (int i = 0; i < 20 && strap_valid !== 1'b1; i++) tk(1);
            own = 7'h60 + {3'h0, s_hi, 2'h0} + {5'h00, s_lo};
            chk({1'b0, tx_a}, {1'b0, exp_tx(tx_strap)});
            chk(tx_w, {exp_tx(tx_strap), 1'b0});
            chk({1'b0, rx_a}, {1'b0, own});
            chk(rx_w, {own, 1'b0});
        end
        tx_strap <= ~tx_strap;
        s_lo <= ~s_lo;
        tk(10);
        chk({1'b0, rx_a}, {1'b0, own});
        chk({1'b0, tx_a}, {1'b0, exp_tx(~tx_strap)});
        for (int i = 0; i < `SAL_ALIAS_N; i++)
            alias_table[i] <= {1'b1, 7'h50 + 7'(i), 7'($urandom)};
        d = 8'($urandom);
        i2c_start();
        send({own, 1'b0}, ack);
        chk({7'h00, ack}, 8'h01);
        send(d, ack);
        chk({7'h00, ack}, 8'h01);
        chk(wr_seen, d);
        i2c_stop();
        // Own register read twice, then one aliased remote byte
        rd_data <= 8'($urandom);
        i2c_start();
        send({own, 1'b1}, ack);
        chk({7'h00, ack}, 8'h01);
        recv(1'b0, d);
        chk(d, rd_data);
        recv(1'b1, d);
        chk(d, rd_data);
        i2c_stop();
        chk(8'(rd_n), 8'h02);
        i2c_start();
        send({7'h50, 1'b1}, ack);
        recv(1'b1, d);
        i2c_stop();
        chk(d, {alias_table[0].target, 1'b1} ^ 8'hA5);
        chk(last_addr, {alias_table[0].target, 1'b1});
        // Every alias entry, stretched while the remote answers
        for (int i = 0; i < `SAL_ALIAS_N; i++) begin
            xfer(7'h50 + 7'(i), ack);
            chk({7'h00, ack}, 8'h01);
            chk({7'h00, stretched}, 8'h01);
            chk(last_addr, {alias_table[i].target, 1'b0});
        end
        camera_mode <= 1'b0;
        xfer(7'h53, ack);
        chk({7'h00, ack}, 8'h00);
        pass_through_en <= 1'b1;
        xfer(7'h53, ack);
        chk({7'h00, ack}, 8'h01);
        chk(last_addr, {7'h53, 1'b0});
        camera_mode <= 1'b1;
        pass_through_en <= 1'b0;
        xfer(7'h40, ack);
        chk({7'h00, ack}, 8'h00);
        remote_ack <= 1'b0;
        xfer(7'h52, ack);
        chk({7'h00, ack}, 8'h00);
        final_report();
    end
endmodule : sal_alias_bridge_tb
`default_nettype wire
